// *** rtl/dac_status_flag_bank.v ***
// Behaviour
// (R1) left DAC, headphone, class-D power in D7,D5,D4
// (R2) right DAC, headphone, class-D power in D3,D1,D0
// (R3) gain D4 high while left gain reached
// (R4) gain D0 high while right gain reached
// (R5) overflow D7 left, D6 right DAC
// (R6) overflow D5 on barrel shifter overflow
// (R7) sticky flags clear on read, set again on recurrence
// (R8) sticky D7 on left short circuit
// (R9) sticky D6 on right short circuit
// (R10) button press in sticky and live D5
// (R11) sticky D4 on headset insert or removal
// (R12) live D4 shows headset inserted state
// (R13) sticky D3/D2 on compressor threshold exceeded
// (R14) live D3/D2 show power above threshold
// (R15) live D7/D6 show current short circuit
// (R16) software writes only zero to reserved 0x2F
// (R17) repeat mode pulses until sticky register read
// (R18) overflow raises interrupt when enable set
// (R19) event during clearing read keeps flag set
`timescale 1ns/1ps
`include "dac_status_flag_bank_defs.vh"
module dac_status_flag_bank #(
  parameter PULSE_WIDTH_CYC  = `PULSE_WIDTH_CYC,
  parameter PULSE_PERIOD_CYC = `PULSE_PERIOD_CYC
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // register port
  input  wire [7:0] reg_addr,
  input  wire       reg_rd,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] rdata_ff,
  // power state inputs
  input  wire       l_dac_on,
  input  wire       left_headphone_driver_on,
  input  wire       l_clsd_on,
  input  wire       r_dac_on,
  input  wire       right_headphone_driver_on,
  input  wire       r_clsd_on,
  // digital_gain_stage status
  input  wire       l_gain_reached,
  input  wire       r_gain_reached,
  // overflow event pulses
  input  wire       l_ovf_evt,
  input  wire       r_ovf_evt,
  input  wire       shift_ovf_evt,
  // live conditions
  input  wire       l_short,
  input  wire       r_short,
  input  wire       button_pressed,
  input  wire       headset_present,
  input  wire       l_over_thr,
  input  wire       r_over_thr,
  // interrupt
  output reg        first_interrupt_output_ff
);

  reg  [7:0]  int_ctrl_ff;
  reg  [7:0]  rsvd_c_ff;
  reg  [6:0]  live_ff;
  reg         headset_prev_ff;
  reg         short_l_prev_ff;
  reg         short_r_prev_ff;
  reg         button_prev_ff;
  reg         thr_l_prev_ff;
  reg         thr_r_prev_ff;
  reg  [7:0]  nxt_rdata;
  wire [2:0]  ovf_q;
  wire [5:0]  evt_q;
  wire [2:0]  ovf_set;
  wire [5:0]  evt_set;
  wire        rd_ovf;
  wire        rd_evt;

  assign rd_ovf = reg_rd && (reg_addr == `OFS_OVERFLOW);   // [R7]
  assign rd_evt = reg_rd && (reg_addr == `OFS_STICKY_EVENT); // [R7]

  assign ovf_set = {l_ovf_evt, r_ovf_evt, shift_ovf_evt}; // [R5] [R6]
  // rising edges (both edges for headset) so a held condition latches once per occurrence
  assign evt_set = {
    l_short & ~short_l_prev_ff,                 // [R8]
    r_short & ~short_r_prev_ff,                 // [R9]
    button_pressed & ~button_prev_ff,           // [R10]
    headset_present ^ headset_prev_ff,          // [R11]
    l_over_thr & ~thr_l_prev_ff,                // [R13]
    r_over_thr & ~thr_r_prev_ff                 // [R13]
  };

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ovf
      sticky_bit u_bit (
        .clk     (clk),
        .rst     (rst),
        .set_evt (ovf_set[gi]),
        .clr     (rd_ovf),
        .flag_ff (ovf_q[gi])
      ); // [R19]
    end
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_evt
      sticky_bit u_bit (
        .clk     (clk),
        .rst     (rst),
        .set_evt (evt_set[gi]),
        .clr     (rd_evt),
        .flag_ff (evt_q[gi])
      ); // [R19]
    end
  endgenerate

  // edge history and live copies
  always @(posedge clk) begin
    if (rst) begin
      short_l_prev_ff <= 1'b0;
      short_r_prev_ff <= 1'b0;
      button_prev_ff  <= 1'b0;
      headset_prev_ff <= 1'b0;
      thr_l_prev_ff   <= 1'b0;
      thr_r_prev_ff   <= 1'b0;
      live_ff         <= 7'h00;
    end else begin
      short_l_prev_ff <= l_short;
      short_r_prev_ff <= r_short;
      button_prev_ff  <= button_pressed;
      headset_prev_ff <= headset_present;
      thr_l_prev_ff   <= l_over_thr;
      thr_r_prev_ff   <= r_over_thr;
      live_ff         <= {l_short, r_short,           // [R15]
                          button_pressed,             // [R10]
                          headset_present,            // [R12]
                          l_over_thr, r_over_thr,     // [R14]
                          1'b0};
    end
  end

  // writable registers; reserved one accepts writes, stays software's duty
  always @(posedge clk) begin
    if (rst) begin
      int_ctrl_ff <= `RESET_INT_CTRL;
      rsvd_c_ff   <= `RESET_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_INT_CTRL) begin
        int_ctrl_ff <= reg_wdata;
      end
      if (reg_addr == `OFS_RSVD_C) begin
        rsvd_c_ff <= reg_wdata; // [R16]
      end
    end
  end

  always @* begin
    nxt_rdata = `RESET_BYTE;
    case (reg_addr)
      `OFS_POWER_STATE: begin
        nxt_rdata[`PWR_L_DAC]  = l_dac_on;                  // [R1]
        nxt_rdata[`PWR_L_HP]   = left_headphone_driver_on;  // [R1]
        nxt_rdata[`PWR_L_CLSD] = l_clsd_on;                 // [R1]
        nxt_rdata[`PWR_R_DAC]  = r_dac_on;                  // [R2]
        nxt_rdata[`PWR_R_HP]   = right_headphone_driver_on; // [R2]
        nxt_rdata[`PWR_R_CLSD] = r_clsd_on;                 // [R2]
      end
      `OFS_GAIN_REACHED: begin
        nxt_rdata[`GAIN_L] = l_gain_reached; // [R3]
        nxt_rdata[`GAIN_R] = r_gain_reached; // [R4]
      end
      `OFS_OVERFLOW: begin
        nxt_rdata = {ovf_q, 5'h00}; // [R5] [R6]
      end
      `OFS_STICKY_EVENT: begin
        nxt_rdata = {evt_q, 2'h0}; // [R8] [R9] [R10] [R11] [R13]
      end
      `OFS_LIVE_EVENT: begin
        nxt_rdata = {live_ff, 1'b0};
      end
      `OFS_RSVD_C: begin
        nxt_rdata = rsvd_c_ff;
      end
      `OFS_INT_CTRL: begin
        nxt_rdata = int_ctrl_ff;
      end
      default: begin
        nxt_rdata = `RESET_BYTE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      rdata_ff <= `RESET_BYTE;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // interrupt pulse generator
  localparam ST_IDLE  = 1'b0;
  localparam ST_PULSE = 1'b1;
  localparam CW = 24;

  reg          state_ff;
  reg [CW-1:0] cnt_ff;
  reg          repeat_ff;
  wire         ovf_trig;

  assign ovf_trig = int_ctrl_ff[`ICTL_OVF_EN] && (|ovf_set); // [R18]

  always @(posedge clk) begin
    if (rst) begin
      state_ff                  <= ST_IDLE;
      cnt_ff                    <= {CW{1'b0}};
      repeat_ff                 <= 1'b0;
      first_interrupt_output_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          first_interrupt_output_ff <= 1'b0;
          if (ovf_trig) begin
            state_ff                  <= ST_PULSE;
            cnt_ff                    <= {CW{1'b0}};
            repeat_ff                 <= int_ctrl_ff[`ICTL_REPEAT];
            first_interrupt_output_ff <= 1'b1;
          end
        end
        ST_PULSE: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == PULSE_WIDTH_CYC[CW-1:0] - 1'b1) begin
            first_interrupt_output_ff <= 1'b0;
          end
          // repeats stop once software reads the sticky event register
          if (rd_evt) begin
            repeat_ff <= 1'b0; // [R17]
          end
          if (cnt_ff == PULSE_PERIOD_CYC[CW-1:0] - 1'b1) begin
            cnt_ff <= {CW{1'b0}};
            if (repeat_ff && !rd_evt) begin
              first_interrupt_output_ff <= 1'b1; // [R17]
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** rtl/dac_status_flag_bank_defs.vh ***
`ifndef DAC_STATUS_FLAG_BANK_DEFS_VH
`define DAC_STATUS_FLAG_BANK_DEFS_VH

// register offsets
`define OFS_POWER_STATE   8'h25
`define OFS_GAIN_REACHED  8'h26
`define OFS_OVERFLOW      8'h27
`define OFS_RSVD_A0       8'h28
`define OFS_RSVD_A3       8'h2B
`define OFS_STICKY_EVENT  8'h2C
`define OFS_RSVD_B        8'h2D
`define OFS_LIVE_EVENT    8'h2E
`define OFS_RSVD_C        8'h2F
`define OFS_INT_CTRL      8'h30

// power state bits
`define PWR_L_DAC         7
`define PWR_L_HP          5
`define PWR_L_CLSD        4
`define PWR_R_DAC         3
`define PWR_R_HP          1
`define PWR_R_CLSD        0

// gain reached bits
`define GAIN_L            4
`define GAIN_R            0

// overflow bits
`define OVF_L             7
`define OVF_R             6
`define OVF_SHIFT         5

// event bits (sticky and live share positions)
`define EVT_SHORT_L       7
`define EVT_SHORT_R       6
`define EVT_BUTTON        5
`define EVT_HEADSET       4
`define EVT_THR_L         3
`define EVT_THR_R         2

// interrupt control bits
`define ICTL_OVF_EN       2
`define ICTL_REPEAT       0

`define RESET_BYTE        8'h00
`define RESET_INT_CTRL    8'h00

// pulse timing
`define CLK_PERIOD_PS     5000
`define PULSE_WIDTH_US    2000
`define PULSE_PERIOD_US   4000
// scaled in ns so the 32-bit arithmetic cannot overflow
`define PULSE_WIDTH_CYC   ((`PULSE_WIDTH_US * 1000) / (`CLK_PERIOD_PS / 1000))
`define PULSE_PERIOD_CYC  ((`PULSE_PERIOD_US * 1000) / (`CLK_PERIOD_PS / 1000))

`endif

// *** rtl/sticky_bit.v ***
`timescale 1ns/1ps
module sticky_bit (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // control
  input  wire set_evt,
  input  wire clr,
  // state
  output reg  flag_ff
);

  // set wins over the clear so an event is never lost
  always @(posedge clk) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (set_evt) begin
      flag_ff <= 1'b1;
    end else if (clr) begin
      flag_ff <= 1'b0;
    end
  end

endmodule

// *** testbench/flag_bank_chk_assertions.sv ***
`timescale 1ns/1ps
module flag_bank_chk #(
  parameter PULSE_WIDTH_CYC  = 4,
  parameter PULSE_PERIOD_CYC = 8
) (
  // clock, reset, register port
  input wire       clk,
  input wire       rst,
  input wire [7:0] reg_addr,
  input wire       reg_rd,
  input wire [7:0] rdata_ff,
  // status sources
  input wire       l_dac_on,
  input wire       left_headphone_driver_on,
  input wire       l_clsd_on,
  input wire       l_gain_reached,
  input wire       r_gain_reached,
  input wire       l_ovf_evt,
  input wire       r_ovf_evt,
  input wire       shift_ovf_evt,
  input wire       l_short,
  input wire       r_short,
  input wire       headset_present,
  input wire       l_over_thr,
  input wire       r_over_thr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire rd27 = reg_rd && reg_addr == 8'h27;
  wire rd2c = reg_rd && reg_addr == 8'h2C;
  wire any_ovf = l_ovf_evt || r_ovf_evt || shift_ovf_evt;
  a_power_left: assert property (reg_rd && reg_addr == 8'h25 |=>
    rdata_ff[7] == $past(l_dac_on) && rdata_ff[4] == $past(l_clsd_on)
    && rdata_ff[5] == $past(left_headphone_driver_on)) else $error("power");
  a_gain_bits: assert property (reg_rd && reg_addr == 8'h26 |=>
    rdata_ff[4] == $past(l_gain_reached)
    && rdata_ff[0] == $past(r_gain_reached)) else $error("gain bits");
  a_ovf_left: assert property (l_ovf_evt ##1 !reg_rd [*2] ##1 rd27
    |=> rdata_ff[7]) else $error("left overflow lost");
  a_ovf_shift: assert property (shift_ovf_evt ##1 !reg_rd [*2] ##1 rd27
    |=> rdata_ff[5]) else $error("shifter overflow lost");
  a_read_clears: assert property ((rd27 && !any_ovf) ##1 rd27
    |=> rdata_ff[7:5] == 3'h0) else $error("flags not cleared");
  a_set_wins: assert property ((rd27 && l_ovf_evt) ##1 (rd27 && !any_ovf)
    |=> rdata_ff[7]) else $error("event lost on read");
  a_live_copy: assert property (reg_rd && reg_addr == 8'h2E |=>
    rdata_ff[7:6] == {$past(l_short, 2), $past(r_short, 2)}
    && rdata_ff[4:2] == {$past(headset_present, 2), $past(l_over_thr, 2),
    $past(r_over_thr, 2)}) else $error("live copy");
  a_headset_sticky: assert property ($changed(headset_present)
    ##1 !reg_rd ##1 rd2c |=> rdata_ff[4]) else $error("headset change lost");
endmodule

bind dac_status_flag_bank flag_bank_chk #(
  .PULSE_WIDTH_CYC(PULSE_WIDTH_CYC), .PULSE_PERIOD_CYC(PULSE_PERIOD_CYC)
) i_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .rdata_ff(rdata_ff), .l_dac_on(l_dac_on), .l_clsd_on(l_clsd_on),
  .left_headphone_driver_on(left_headphone_driver_on),
  .l_gain_reached(l_gain_reached), .r_gain_reached(r_gain_reached),
  .l_ovf_evt(l_ovf_evt), .r_ovf_evt(r_ovf_evt),
  .shift_ovf_evt(shift_ovf_evt), .l_short(l_short), .r_short(r_short),
  .headset_present(headset_present), .l_over_thr(l_over_thr),
  .r_over_thr(r_over_thr)
);

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  reg        clk = 1'h0;
  reg        rst = 1'h1;
  reg  [7:0] reg_addr = 8'h00;
  reg        reg_rd = 1'h0;
  reg        reg_wr = 1'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg  [5:0] pw = 6'h00;
  reg  [1:0] gn = 2'h0;
  reg  [2:0] ov = 3'h0;
  reg  [5:0] lv = 6'h00;
  reg  [7:0] r;
  wire [7:0] rdata_ff;
  wire       irq;
  integer    seed = 32'hAF6AFAF2;
  integer    n_fail = 0;
  integer    n_compared = 0;
  integer    i;
  always #2.5 clk = ~clk;
  dac_status_flag_bank #(.PULSE_WIDTH_CYC(4), .PULSE_PERIOD_CYC(8)) i_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .rdata_ff(rdata_ff),
    .l_dac_on(pw[5]), .left_headphone_driver_on(pw[4]), .l_clsd_on(pw[3]),
    .r_dac_on(pw[2]), .right_headphone_driver_on(pw[1]), .r_clsd_on(pw[0]),
    .l_gain_reached(gn[1]), .r_gain_reached(gn[0]), .l_ovf_evt(ov[2]),
    .r_ovf_evt(ov[1]), .shift_ovf_evt(ov[0]), .l_short(lv[5]),
    .r_short(lv[4]), .button_pressed(lv[3]), .headset_present(lv[2]),
    .l_over_thr(lv[1]), .r_over_thr(lv[0]), .first_interrupt_output_ff(irq));
  function [7:0] pexp(input [5:0] p);
    pexp = {p[5], 1'h0, p[4:2], 1'h0, p[1:0]};
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] e, input [7:0] m);
    begin
      @(posedge clk);
      reg_rd   <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk(rdata_ff & m, e & m);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_wr    <= 1'h1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
    end
  endtask
  task end_sim;
    begin
      if (n_fail == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #20000;
    n_fail = n_fail + 1;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    for (i = 8'h27; i <= 8'h2F; i = i + 1)
      rd(i[7:0], 8'h00, 8'hFF);
    wr(8'h2F, 8'h00);
    wr(8'h2C, 8'hFF);
    rd(8'h2C, 8'h00, 8'hFF);
    for (i = 0; i < 24; i = i + 1) begin
      r = $random(seed);
      // first two passes pin all-low and all-high
      if (i < 2)
        r = {8{i[0]}};
      @(posedge clk);
      pw <= r[5:0];
      gn <= r[7:6];
      rd(8'h25, pexp(r[5:0]), 8'hBB);
      rd(8'h26, {3'h0, r[7], 3'h0, r[6]}, 8'h11);
    end
    wr(8'h30, 8'h04);
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge clk);
      ov <= 3'h1 << i;
      @(posedge clk);
      ov <= 3'h0;
      @(posedge clk);
      #1 chk({7'h00, irq}, 8'h01);
      rd(8'h27, 8'h20 << i, 8'hFF);
      rd(8'h27, 8'h00, 8'hFF);
      // let the single pulse train finish before the next trigger
      repeat (10) @(posedge clk);
      #1 chk({7'h00, irq}, 8'h00);
    end
    wr(8'h30, 8'h05);
    @(posedge clk);
    ov <= 3'h4;
    @(posedge clk);
    ov <= 3'h0;
    repeat (8) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h01);
    rd(8'h2C, 8'h00, 8'hFF);
    rd(8'h27, 8'h80, 8'hFF);
    repeat (12) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= 8'h27;
    ov       <= 3'h4;
    @(posedge clk);
    ov <= 3'h0;
    @(posedge clk);
    #1 chk(rdata_ff, 8'h80);
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(rdata_ff, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge clk);
      lv <= 6'h01 << i;
      @(posedge clk);
      rd(8'h2C, 8'h04 << i, 8'hFF);
      rd(8'h2E, 8'h04 << i, 8'hFC);
      rd(8'h2C, 8'h00, 8'hFF);
      @(posedge clk);
      lv <= 6'h00;
      @(posedge clk);
      rd(8'h2C, (i == 2) ? 8'h10 : 8'h00, 8'hFF);
    end
    end_sim;
  end
endmodule
